// ==== src/dbg_access_pkg.sv ====
// Constants, field layouts and carrier types for the debug access layer.
// Assumes a link layer that delivers register, key and memory requests.
package dbg_access_pkg;
  // Register offsets
  localparam logic [3:0] OFS_REVISION = 4'h0;
  localparam logic [3:0] OFS_ERROR = 4'h1;
  localparam logic [3:0] OFS_LINK_A = 4'h2;
  localparam logic [3:0] OFS_LINK_B = 4'h3;
  localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
  localparam logic [3:0] OFS_RESET_REQ = 4'h8;
  localparam logic [3:0] OFS_CLK_SEL = 4'h9;
  localparam logic [3:0] OFS_SYS_CTRL = 4'ha;
  localparam logic [3:0] OFS_SYS_STATUS = 4'hb;
  localparam logic [3:0] OFS_CRC_STATUS = 4'hc;
  // Reset values and masks
  localparam logic [7:0] REVISION_VALUE = 8'h30;
  localparam logic [7:0] LINK_A_MASK = 8'hbf;
  localparam logic [7:0] LINK_B_MASK = 8'h1c;
  localparam logic [7:0] CLK_SEL_MASK = 8'h03;
  localparam logic [7:0] RESET_SIGNATURE = 8'h59;
  localparam logic [7:0] RESET_CLEAR = 8'h00;
  // Field positions
  localparam int LINK_DISABLE_BIT = 2;
  localparam int KEY_UROW_BIT = 5;
  localparam int KEY_NVM_BIT = 4;
  localparam int KEY_ERASE_BIT = 3;
  localparam int CTRL_FINAL_BIT = 1;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int ST_RESET_BIT = 5;
  localparam int ST_ASLEEP_BIT = 4;
  localparam int ST_NVM_BIT = 3;
  localparam int ST_UROW_BIT = 2;
  localparam int ST_LOCK_BIT = 0;
  // Key signatures
  localparam logic [63:0] KEY_ERASE = 64'h4e564d4572617365;
  localparam logic [63:0] KEY_NVM = 64'h4e564d50726f6720;
  localparam logic [63:0] KEY_UROW = 64'h4e564d5573267465;
  localparam int KEY_BYTES = 8;
  // User-row buffer geometry
  localparam int UROW_BYTES = 32;
  localparam int UROW_AW = 5;
  localparam int MEM_AW = 16;

  typedef struct packed {
    logic we;
    logic [MEM_AW-1:0] addr;
    logic [7:0] data;
  } mem_req_t;

  typedef struct packed {
    logic urow;
    logic nvm;
    logic erase;
  } key_hits_t;

  typedef enum logic [4:0] {
    SES_IDLE = 5'b00001,
    SES_ERASE = 5'b00010,
    SES_NVM = 5'b00100,
    SES_UROW = 5'b01000,
    SES_COPY = 5'b10000
  } session_t;
endpackage

// ==== src/key_matcher.sv ====
// Shifts in 64-bit key signatures a byte at a time and compares them.
// Assumes key_start precedes each key and bytes arrive least first.
`timescale 1ns/1ps
module key_matcher
(
  input wire logic clk,
  input wire logic reset,
  input wire logic key_start,
  input wire logic key_valid,
  input wire logic [7:0] key_byte,
  output dbg_access_pkg::key_hits_t hits
);
  logic [63:0] shift_r;
  logic [63:0] shift_nxt;
  logic [3:0] count_r;
  logic last_byte;

  // Newest byte enters at the top so the first byte ends lowest
  assign shift_nxt = {key_byte, shift_r[63:8]};
  assign last_byte = key_valid &&
    (count_r == 4'(dbg_access_pkg::KEY_BYTES - 1));

  // Byte counter restarts on each key frame
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      shift_r <= 64'h0;
      count_r <= 4'h0;
      hits <= '0;
    end
    else
    begin
      hits <= '0;
      if (key_start)
        count_r <= 4'h0;
      else if (key_valid)
      begin
        shift_r <= shift_nxt;
        count_r <= last_byte ? 4'h0 : count_r + 4'h1;
        if (last_byte)
        begin
          hits.erase <= shift_nxt == dbg_access_pkg::KEY_ERASE;
          hits.nvm <= shift_nxt == dbg_access_pkg::KEY_NVM;
          hits.urow <= shift_nxt == dbg_access_pkg::KEY_UROW;
        end
      end
    end
  end
endmodule

// ==== src/user_row_copier.sv ====
// Copies the RAM staging buffer into the user row, byte for byte.
// Assumes RAM read data is valid in the same cycle as the address.
`timescale 1ns/1ps
module user_row_copier
#(
  parameter int BYTES = dbg_access_pkg::UROW_BYTES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] ram_rd_data,
  output logic [dbg_access_pkg::UROW_AW-1:0] ram_rd_addr,
  output logic urow_wr,
  output logic [dbg_access_pkg::UROW_AW-1:0] urow_addr,
  output logic [7:0] urow_data,
  output logic done
);
  logic busy_r;
  logic fetch_r;
  logic last_addr;

  assign last_addr = ram_rd_addr == dbg_access_pkg::UROW_AW'(BYTES - 1);

  // One byte fetched per cycle; write trails fetch by one cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      busy_r <= 1'b0;
      fetch_r <= 1'b0;
      ram_rd_addr <= '0;
      urow_wr <= 1'b0;
      urow_addr <= '0;
      urow_data <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      urow_wr <= fetch_r;
      done <= 1'b0;
      if (fetch_r)
      begin
        urow_addr <= ram_rd_addr;
        urow_data <= ram_rd_data;
      end
      if (start && !busy_r)
      begin
        busy_r <= 1'b1;
        fetch_r <= 1'b1;
        ram_rd_addr <= '0;
      end
      else if (fetch_r)
      begin
        if (last_addr)
          fetch_r <= 1'b0;
        else
          ram_rd_addr <= ram_rd_addr + 1'b1;
      end
      else if (busy_r && !urow_wr)
      begin
        busy_r <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule

// ==== src/debug_key_nvm_access.sv ====
// Access-security layer of the single-wire debug port: registers,
// key sessions, system reset, memory gating, sleep and sync event.
// Assumes the link layer decodes frames and hands over register,
// key and memory requests as one-cycle strobes on clk.
`timescale 1ns/1ps
module debug_key_nvm_access
(
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic key_start,
  input wire logic key_valid,
  input wire logic [7:0] key_byte,
  input wire logic mem_valid,
  input wire dbg_access_pkg::mem_req_t mem_req,
  output logic mem_accept,
  output logic mem_refused,
  output logic bus_valid,
  output dbg_access_pkg::mem_req_t bus_req,
  input wire logic sync_pin,
  output logic sync_character_event,
  input wire logic lock_in,
  input wire logic sys_asleep,
  input wire logic sys_clk_stopped,
  input wire logic supply_low,
  input wire logic erase_done,
  input wire logic link_error_valid,
  input wire logic [2:0] link_error_code,
  input wire logic [2:0] crc_status_in,
  output logic system_reset,
  output logic erase_start,
  output logic bod_force,
  output logic clock_request,
  output logic sleep_emulate,
  output logic [7:0] link_ctrl_a,
  output logic [7:0] link_ctrl_b,
  output logic [1:0] clock_select,
  input wire logic [7:0] ram_rd_data,
  output logic [dbg_access_pkg::UROW_AW-1:0] ram_rd_addr,
  output logic urow_wr,
  output logic [dbg_access_pkg::UROW_AW-1:0] urow_addr,
  output logic [7:0] urow_data
);
  dbg_access_pkg::session_t session_r;
  dbg_access_pkg::session_t session_nxt;
  dbg_access_pkg::key_hits_t hits;
  logic [2:0] error_r;
  logic [2:0] keys_r;
  logic [7:0] reset_req_r;
  logic system_clock_hold_r;
  logic asleep_r;
  logic copy_start_r;
  logic copy_done;
  logic [7:0] rd_value;
  logic [7:0] key_status_value;
  logic [7:0] sys_status_value;
  logic wr_link_a;
  logic wr_link_b;
  logic wr_key;
  logic wr_rst;
  logic wr_clk_sel;
  logic wr_ctrl;
  logic rd_error;
  logic link_enabled;
  logic sig_write;
  logic release_write;
  logic final_write;
  logic urow_close;
  logic unavailable;
  logic bus_blocked;
  logic urow_mode;
  logic in_buffer;
  logic drop_write;

  // Register strobes decoded from the debug link only; no CPU path
  function automatic logic hit(input logic [3:0] a,
                               input logic [3:0] ofs);
    hit = a == ofs;
  endfunction

  assign wr_link_a = reg_wr && hit(reg_addr, dbg_access_pkg::OFS_LINK_A);
  assign wr_link_b = reg_wr && hit(reg_addr, dbg_access_pkg::OFS_LINK_B);
  assign wr_key = reg_wr && hit(reg_addr, dbg_access_pkg::OFS_KEY_STATUS);
  assign wr_rst = reg_wr && hit(reg_addr, dbg_access_pkg::OFS_RESET_REQ);
  assign wr_clk_sel = reg_wr && hit(reg_addr, dbg_access_pkg::OFS_CLK_SEL);
  assign wr_ctrl = reg_wr && hit(reg_addr, dbg_access_pkg::OFS_SYS_CTRL);
  assign rd_error = reg_rd && hit(reg_addr, dbg_access_pkg::OFS_ERROR);

  // Reset signature asserts, zero releases; other values only stored
  assign sig_write = wr_rst &&
    (reg_wdata == dbg_access_pkg::RESET_SIGNATURE);
  assign release_write = wr_rst && system_reset &&
    (reg_wdata == dbg_access_pkg::RESET_CLEAR);
  assign final_write = wr_ctrl &&
    reg_wdata[dbg_access_pkg::CTRL_FINAL_BIT];
  assign urow_close = wr_key && reg_wdata[dbg_access_pkg::KEY_UROW_BIT];
  assign link_enabled = !link_ctrl_b[dbg_access_pkg::LINK_DISABLE_BIT];

  // Status views assembled from live state
  assign key_status_value = {2'b00, keys_r, 3'b000};
  assign sys_status_value = {2'b00, system_reset, asleep_r,
    session_r == dbg_access_pkg::SES_NVM,
    urow_mode, 1'b0, lock_in};
  assign urow_mode = (session_r == dbg_access_pkg::SES_UROW) ||
    (session_r == dbg_access_pkg::SES_COPY);

  // Offsets 0-3 face the link layer, 7-12 the access layer; 4-6 read as zero
  assign rd_value =
    hit(reg_addr, dbg_access_pkg::OFS_REVISION) ?
      dbg_access_pkg::REVISION_VALUE :
    hit(reg_addr, dbg_access_pkg::OFS_ERROR) ? {5'b00000, error_r} :
    hit(reg_addr, dbg_access_pkg::OFS_LINK_A) ? link_ctrl_a :
    hit(reg_addr, dbg_access_pkg::OFS_LINK_B) ? link_ctrl_b :
    hit(reg_addr, dbg_access_pkg::OFS_KEY_STATUS) ? key_status_value :
    hit(reg_addr, dbg_access_pkg::OFS_RESET_REQ) ? reset_req_r :
    hit(reg_addr, dbg_access_pkg::OFS_CLK_SEL) ? {6'b000000, clock_select} :
    hit(reg_addr, dbg_access_pkg::OFS_SYS_CTRL) ?
      {7'b0000000, system_clock_hold_r} :
    hit(reg_addr, dbg_access_pkg::OFS_SYS_STATUS) ? sys_status_value :
    hit(reg_addr, dbg_access_pkg::OFS_CRC_STATUS) ?
      {5'b00000, crc_status_in} :
    8'h00;

  // Memory gating; reset, erase, a locked part outside the user-row session and a stopped clock without clock request all block
  assign unavailable = (session_r == dbg_access_pkg::SES_ERASE) &&
    supply_low;
  assign bus_blocked = system_reset || unavailable || !link_enabled ||
    (session_r == dbg_access_pkg::SES_ERASE) ||
    (sys_clk_stopped && !clock_request) ||
    (lock_in && !urow_mode);
  assign in_buffer = mem_req.addr <
    dbg_access_pkg::MEM_AW'(dbg_access_pkg::UROW_BYTES);
  assign drop_write = urow_mode && mem_req.we && !in_buffer;

  // Session sequencing on reset release and completion events
  always_comb
  begin
    session_nxt = session_r;
    case (session_r)
      dbg_access_pkg::SES_IDLE:
      begin
        if (release_write && keys_r[2'(dbg_access_pkg::KEY_ERASE_BIT - 3)])
          session_nxt = dbg_access_pkg::SES_ERASE;
        else if (release_write && keys_r[1] && !lock_in)
          session_nxt = dbg_access_pkg::SES_NVM;
        else if (release_write && keys_r[2] && lock_in)
          session_nxt = dbg_access_pkg::SES_UROW;
      end
      dbg_access_pkg::SES_ERASE:
        if (erase_done)
          session_nxt = dbg_access_pkg::SES_IDLE;
      dbg_access_pkg::SES_NVM:
        if (sig_write)
          session_nxt = dbg_access_pkg::SES_IDLE;
      dbg_access_pkg::SES_UROW:
        if (final_write)
          session_nxt = dbg_access_pkg::SES_COPY;
      dbg_access_pkg::SES_COPY:
        if (copy_done)
          session_nxt = dbg_access_pkg::SES_IDLE;
      default:
        session_nxt = dbg_access_pkg::SES_IDLE;
    endcase
    if (!link_enabled)
      session_nxt = dbg_access_pkg::SES_IDLE;
  end

  // Session state and the outputs it drives
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      session_r <= dbg_access_pkg::SES_IDLE;
      erase_start <= 1'b0;
      copy_start_r <= 1'b0;
      bod_force <= 1'b0;
    end
    else
    begin
      session_r <= session_nxt;
      erase_start <= (session_r != dbg_access_pkg::SES_ERASE) &&
        (session_nxt == dbg_access_pkg::SES_ERASE);
      copy_start_r <= (session_r == dbg_access_pkg::SES_UROW) &&
        (session_nxt == dbg_access_pkg::SES_COPY);
      bod_force <= session_nxt == dbg_access_pkg::SES_ERASE;
    end
  end

  // Key flags; a new match wins over a key clear in the same cycle; link disable clears all
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      keys_r <= 3'b000;
    else if (!link_enabled)
      keys_r <= 3'b000;
    else
    begin
      if (hits.erase)
        keys_r[0] <= 1'b1;
      else if (release_write)
        keys_r[0] <= 1'b0;
      if (hits.nvm)
        keys_r[1] <= 1'b1;
      else if (session_nxt == dbg_access_pkg::SES_NVM)
        keys_r[1] <= 1'b0;
      if (hits.urow)
        keys_r[2] <= 1'b1;
      else if (urow_close)
        keys_r[2] <= 1'b0;
    end
  end

  // System reset held from signature until zero is written
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reset_req_r <= 8'h00;
      system_reset <= 1'b0;
    end
    else if (wr_rst)
    begin
      reset_req_r <= reg_wdata;
      if (sig_write)
        system_reset <= 1'b1;
      else if (release_write)
        system_reset <= 1'b0;
    end
  end

  // Link configuration; disabling the link wipes control A and re-arms hold
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      link_ctrl_a <= 8'h00;
      link_ctrl_b <= 8'h00;
      clock_select <= 2'b00;
      system_clock_hold_r <= 1'b1;
    end
    else
    begin
      if (wr_link_b)
        link_ctrl_b <= reg_wdata & dbg_access_pkg::LINK_B_MASK;
      if (!link_enabled)
      begin
        link_ctrl_a <= 8'h00;
        system_clock_hold_r <= 1'b1;
      end
      else
      begin
        if (wr_link_a)
          link_ctrl_a <= reg_wdata & dbg_access_pkg::LINK_A_MASK;
        if (wr_clk_sel)
          clock_select <= reg_wdata[1:0];
        if (wr_ctrl)
          system_clock_hold_r <= reg_wdata[dbg_access_pkg::CTRL_HOLD_BIT];
      end
    end
  end

  // Error code sticks until read; a new error beats the read clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      error_r <= 3'b000;
    else if (link_error_valid)
      error_r <= link_error_code;
    else if (rd_error)
      error_r <= 3'b000;
  end

  // Read data, sleep view and clock request; link side never sleeps
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
      asleep_r <= 1'b0;
      clock_request <= 1'b0;
      sleep_emulate <= 1'b0;
      sync_character_event <= 1'b0;
    end
    else
    begin
      if (reg_rd)
        reg_rdata <= rd_value;
      asleep_r <= sys_asleep;
      clock_request <= link_enabled && system_clock_hold_r;
      sleep_emulate <= link_enabled && system_clock_hold_r &&
        sys_asleep;
      sync_character_event <= sync_pin;
    end
  end

  // No event inputs exist; this port only generates its sync event
  // Memory requests forwarded, refused or silently dropped
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bus_valid <= 1'b0;
      bus_req <= '0;
      mem_accept <= 1'b0;
      mem_refused <= 1'b0;
    end
    else
    begin
      bus_valid <= 1'b0;
      mem_accept <= 1'b0;
      mem_refused <= 1'b0;
      if (mem_valid)
      begin
        if (bus_blocked || (urow_mode && !mem_req.we))
          mem_refused <= 1'b1;
        else
        begin
          mem_accept <= 1'b1;
          bus_valid <= !drop_write;
          bus_req <= mem_req;
        end
      end
    end
  end

  key_matcher u_keys
  (
    .clk(clk),
    .reset(reset),
    .key_start(key_start),
    .key_valid(key_valid),
    .key_byte(key_byte),
    .hits(hits)
  );

  user_row_copier #(.BYTES(dbg_access_pkg::UROW_BYTES)) u_copy
  (
    .clk(clk),
    .reset(reset),
    .start(copy_start_r),
    .ram_rd_data(ram_rd_data),
    .ram_rd_addr(ram_rd_addr),
    .urow_wr(urow_wr),
    .urow_addr(urow_addr),
    .urow_data(urow_data),
    .done(copy_done)
  );
endmodule

// ==== bench/debug_key_nvm_access_props.sv ====
// Port checker for the debug access layer.
// Assumes one clock domain.
`timescale 1ns/1ps
module debug_key_nvm_access_props
(
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic mem_valid,
  input wire dbg_access_pkg::mem_req_t mem_req,
  input wire logic mem_accept,
  input wire logic mem_refused,
  input wire logic bus_valid,
  input wire logic sync_pin,
  input wire logic sync_character_event,
  input wire logic lock_in,
  input wire logic sys_asleep,
  input wire logic sys_clk_stopped,
  input wire logic system_reset,
  input wire logic erase_start,
  input wire logic bod_force,
  input wire logic clock_request,
  input wire logic sleep_emulate,
  input wire logic [dbg_access_pkg::UROW_AW-1:0] ram_rd_addr,
  input wire logic urow_wr,
  input wire logic [dbg_access_pkg::UROW_AW-1:0] urow_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Reset request writes
  wire rr_wr = reg_wr && reg_addr == dbg_access_pkg::OFS_RESET_REQ;

  AST_RESET_SET: assert property (rr_wr && reg_wdata == 8'h59 |=> system_reset)
    else $error("no reset");
  AST_RESET_HOLD: assert property (system_reset && !rr_wr |=> system_reset)
    else $error("reset dropped");
  AST_RESET_CLEAR: assert property (system_reset && rr_wr && reg_wdata == 8'h00
    |=> !system_reset)
    else $error("no release");
  AST_SYNC_LEVEL: assert property (sync_character_event == $past(sync_pin))
    else $error("sync event late");
  AST_LOCKED_READ: assert property (mem_valid && !mem_req.we && lock_in
    |=> mem_refused && !bus_valid)
    else $error("locked read");
  AST_ROW_WINDOW: assert property (mem_valid && mem_req.we && lock_in
    && mem_req.addr >= 16'h0020 |=> !bus_valid)
    else $error("row write leaked");
  AST_ONE_ANSWER: assert property (mem_valid |=> mem_accept != mem_refused)
    else $error("not one answer");
  AST_CLK_STOP: assert property (mem_valid && sys_clk_stopped && !clock_request
    |=> mem_refused)
    else $error("clock off access");
  AST_EMULATE: assert property ((clock_request && sys_asleep) [*2]
    |-> sleep_emulate)
    else $error("no emulation");
  AST_COPY_MAP: assert property (urow_wr |-> urow_addr == $past(ram_rd_addr))
    else $error("misplaced byte");
  AST_BOD_ON: assert property (erase_start |-> ##[0:1] bod_force)
    else $error("detector off");

  // Scenarios
  COV_COPY: cover property (urow_wr);
  COV_ERASE: cover property (erase_start);
  COV_REFUSE: cover property (mem_refused);
  COV_SLEEP: cover property (sleep_emulate);
endmodule

bind debug_key_nvm_access debug_key_nvm_access_props
  debug_key_nvm_access_props_inst (.clk(clk), .reset(reset),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .mem_valid(mem_valid), .mem_req(mem_req), .mem_accept(mem_accept),
  .mem_refused(mem_refused), .bus_valid(bus_valid), .sync_pin(sync_pin),
  .sync_character_event(sync_character_event), .lock_in(lock_in),
  .sys_asleep(sys_asleep), .sys_clk_stopped(sys_clk_stopped),
  .system_reset(system_reset), .erase_start(erase_start),
  .bod_force(bod_force), .clock_request(clock_request),
  .sleep_emulate(sleep_emulate), .ram_rd_addr(ram_rd_addr),
  .urow_wr(urow_wr), .urow_addr(urow_addr));

// ==== bench/link_host.sv ====
// Debugger model: register, key and memory requests.
// Assumes strobes are taken at the rising clk edge.
`timescale 1ns/1ps
module link_host
(
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic mem_accept,
  input wire logic mem_refused,
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic key_start,
  output logic key_valid,
  output logic [7:0] key_byte,
  output logic mem_valid,
  output dbg_access_pkg::mem_req_t mem_req
);
  // Idle bus; released data is inverted
  initial
  begin
    {reg_wr, reg_rd, key_start, key_valid, mem_valid} = 5'h00;
    {reg_addr, reg_wdata, key_byte, mem_req} = '0;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk);
    #1;
    {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask

  // Read data taken in the cycle where it stands
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // Key bytes go least significant first
  task automatic key(input logic [63:0] k);
    @(posedge clk);
    #1;
    key_start = 1'b1;
    for (int i = 0; i < dbg_access_pkg::KEY_BYTES; i++)
    begin
      @(posedge clk);
      #1;
      {key_start, key_valid, key_byte} = {2'b01, k[8*i +: 8]};
    end
    @(posedge clk);
    #1;
    {key_valid, key_byte} = {1'b0, ~key_byte};
  endtask

  // Answer caught in either cycle after the request
  task automatic mem(input logic we, input logic [15:0] a,
    input logic [7:0] d, output logic [1:0] ans);
    @(posedge clk);
    #1;
    {mem_valid, mem_req} = {1'b1, we, a, d};
    @(posedge clk);
    #1;
    mem_valid = 1'b0;
    ans = {mem_accept, mem_refused};
    @(posedge clk);
    #1;
    ans |= {mem_accept, mem_refused};
    mem_req = ~mem_req;
  endtask
endmodule

// ==== bench/tb_top.sv ====
// Bench: debugger, memory model and scoreboard.
// Assumes answers one cycle after each request.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
module tb_top;
  logic clk = 1'b0, reset = 1'b1, sync_pin = 1'b0, lock_in = 1'b0;
  logic sys_asleep = 1'b0, sys_clk_stopped = 1'b0, erase_done = 1'b0;
  logic [7:0] ram_rd_data;
  logic reg_wr, reg_rd, key_start, key_valid, mem_valid, mem_accept;
  logic mem_refused, bus_valid, sync_character_event, system_reset, urow_wr;
  logic erase_start, bod_force, clock_request, sleep_emulate;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, key_byte, link_ctrl_a, link_ctrl_b;
  logic [7:0] urow_data, d;
  logic [1:0] clock_select, ans;
  logic [4:0] ram_rd_addr, urow_addr;
  dbg_access_pkg::mem_req_t mem_req, bus_req;
  logic [7:0] ram [32], row [32];
  logic [3:0] ofs [3] = '{4'h2, 4'h3, 4'h9};
  logic [7:0] msk [3] = '{8'hbf, 8'h1c, 8'h03};
  int exp [32];
  integer errors = 0, checks = 0, seed = 76, n_bus = 0, n_erase = 0;

  debug_key_nvm_access debug_key_nvm_access_inst (.clk(clk), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .key_start(key_start),
    .key_valid(key_valid), .key_byte(key_byte), .mem_valid(mem_valid),
    .mem_req(mem_req), .mem_accept(mem_accept), .mem_refused(mem_refused),
    .bus_valid(bus_valid), .bus_req(bus_req), .sync_pin(sync_pin),
    .sync_character_event(sync_character_event), .lock_in(lock_in),
    .sys_asleep(sys_asleep), .sys_clk_stopped(sys_clk_stopped),
    .supply_low(1'b0), .erase_done(erase_done), .link_error_valid(1'b0),
    .link_error_code(3'h0), .crc_status_in(3'h0),
    .system_reset(system_reset), .erase_start(erase_start),
    .bod_force(bod_force), .clock_request(clock_request),
    .sleep_emulate(sleep_emulate), .link_ctrl_a(link_ctrl_a),
    .link_ctrl_b(link_ctrl_b), .clock_select(clock_select),
    .ram_rd_data(ram_rd_data), .ram_rd_addr(ram_rd_addr),
    .urow_wr(urow_wr), .urow_addr(urow_addr), .urow_data(urow_data));
  link_host link_host_inst (.clk(clk), .reg_rdata(reg_rdata),
    .mem_accept(mem_accept), .mem_refused(mem_refused), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .key_start(key_start), .key_valid(key_valid), .key_byte(key_byte),
    .mem_valid(mem_valid), .mem_req(mem_req));

  always #2 clk = ~clk;

  // System side: RAM, user row capture, sync noise
  assign ram_rd_data = ram[ram_rd_addr];
  always @(posedge clk)
  begin
    if (bus_valid && bus_req.we && bus_req.addr < 16'h0020)
      ram[bus_req.addr[4:0]] <= bus_req.data;
    if (urow_wr)
      row[urow_addr] <= urow_data;
    n_bus <= n_bus + int'(bus_valid);
    n_erase <= n_erase + int'(erase_start);
    if (!reset)
      sync_pin <= #1 1'($random(seed));
  end

  task automatic reg_chk(input logic [3:0] a, input logic [7:0] e);
    link_host_inst.rd(a, d);
    `CHK("register", e, d)
  endtask

  // Signature then zero; release opens a keyed session
  task automatic cycle();
    link_host_inst.wr(dbg_access_pkg::OFS_RESET_REQ, 8'h59);
    link_host_inst.rd(dbg_access_pkg::OFS_SYS_STATUS, d);
    `CHK("reset flag", 1'b1, d[5])
    `CHK("system_reset", 1'b1, system_reset)
    link_host_inst.wr(dbg_access_pkg::OFS_RESET_REQ, 8'h00);
    @(posedge clk);
    #1;
    `CHK("system_reset", 1'b0, system_reset)
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog well past the few hundred cycles needed
  initial
  begin
    #80000;
    errors++;
    test_done();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    link_host_inst.wr(dbg_access_pkg::OFS_REVISION, 8'hff);
    `CHK("clock_request", 1'b1, clock_request)
    reg_chk(dbg_access_pkg::OFS_REVISION, 8'h30);
    reg_chk(dbg_access_pkg::OFS_SYS_CTRL, 8'h01);
    reg_chk(4'h5, 8'h00);
    foreach (ofs[i])
    begin
      d = 8'($random(seed)) & 8'hfb;
      link_host_inst.wr(ofs[i], d);
      reg_chk(ofs[i], d & msk[i]);
    end
    // Disable wipes control A and drops the clock request
    link_host_inst.wr(dbg_access_pkg::OFS_LINK_A, 8'h05);
    link_host_inst.wr(dbg_access_pkg::OFS_LINK_B, 8'h04);
    link_host_inst.wr(dbg_access_pkg::OFS_LINK_A, 8'h11);
    reg_chk(dbg_access_pkg::OFS_LINK_A, 8'h00);
    `CHK("clock_request", 1'b0, clock_request)
    link_host_inst.wr(dbg_access_pkg::OFS_LINK_B, 8'h00);
    reg_chk(dbg_access_pkg::OFS_SYS_CTRL, 8'h01);
    `CHK("clock_request", 1'b1, clock_request)
    $display("test registers done");
    // NVM session, unlocked part
    link_host_inst.key(dbg_access_pkg::KEY_NVM);
    reg_chk(dbg_access_pkg::OFS_KEY_STATUS, 8'h10);
    cycle();
    reg_chk(dbg_access_pkg::OFS_SYS_STATUS, 8'h08);
    reg_chk(dbg_access_pkg::OFS_KEY_STATUS, 8'h00);
    link_host_inst.mem(1'b1, 16'h0100, 8'h5a, ans);
    `CHK("nvm write", 2'b10, ans)
    cycle();
    reg_chk(dbg_access_pkg::OFS_SYS_STATUS, 8'h00);
    $display("test nvm done");
    // Erase forces the detector, blocks memory
    link_host_inst.key(dbg_access_pkg::KEY_ERASE);
    reg_chk(dbg_access_pkg::OFS_KEY_STATUS, 8'h08);
    cycle();
    `CHK("bod_force", 1'b1, bod_force)
    link_host_inst.mem(1'b1, 16'h0100, 8'h33, ans);
    `CHK("erase access", 2'b01, ans)
    erase_done = 1'b1;
    @(posedge clk);
    #1;
    erase_done = 1'b0;
    reg_chk(dbg_access_pkg::OFS_KEY_STATUS, 8'h00);
    `CHK("bod_force", 1'b0, bod_force)
    `CHK("erase starts", 1, n_erase)
    $display("test erase done");
    // Locked user row, one write past the buffer
    lock_in = 1'b1;
    link_host_inst.key(dbg_access_pkg::KEY_UROW);
    reg_chk(dbg_access_pkg::OFS_KEY_STATUS, 8'h20);
    cycle();
    reg_chk(dbg_access_pkg::OFS_SYS_STATUS, 8'h05);
    for (int i = 0; i < 33; i++)
    begin
      d = 8'($random(seed));
      if (i < 32)
        exp[i] = d;
      link_host_inst.mem(1'b1, (i < 32) ? 16'(i) : 16'h0028, d, ans);
      `CHK("row write", 2'b10, ans)
    end
    `CHK("bus writes", 33, n_bus)
    link_host_inst.mem(1'b0, 16'h0003, 8'h00, ans);
    `CHK("row read", 2'b01, ans)
    link_host_inst.wr(dbg_access_pkg::OFS_SYS_CTRL, 8'h03);
    d = 8'h04;
    for (int i = 0; i < 40 && d[2] !== 1'b0; i++)
      link_host_inst.rd(dbg_access_pkg::OFS_SYS_STATUS, d);
    `CHK("row busy", 1'b0, d[2])
    foreach (exp[i])
      `CHK("user row", exp[i][7:0], row[i])
    link_host_inst.wr(dbg_access_pkg::OFS_KEY_STATUS, 8'h20);
    reg_chk(dbg_access_pkg::OFS_KEY_STATUS, 8'h00);
    cycle();
    reg_chk(dbg_access_pkg::OFS_SYS_STATUS, 8'h01);
    lock_in = 1'b0;
    $display("test user row done");
    // Sleep: held clock keeps the bus open
    {sys_asleep, sys_clk_stopped} = 2'b11;
    reg_chk(dbg_access_pkg::OFS_SYS_STATUS, 8'h10);
    `CHK("sleep_emulate", 1'b1, sleep_emulate)
    link_host_inst.mem(1'b1, 16'h0200, 8'h11, ans);
    `CHK("held clock access", 2'b10, ans)
    link_host_inst.wr(dbg_access_pkg::OFS_SYS_CTRL, 8'h00);
    link_host_inst.mem(1'b1, 16'h0200, 8'h22, ans);
    `CHK("stopped clock access", 2'b01, ans)
    reg_chk(dbg_access_pkg::OFS_SYS_CTRL, 8'h00);
    $display("test sleep done");
    test_done();
  end
endmodule
